// ### vac_pkg.sv
package vac_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned VAC_WORD_W = 16;
  localparam int unsigned VAC_BAND_W = 8;
  localparam int unsigned VAC_INT_W = 19;
  localparam int unsigned VAC_FRAC_W = 24;
  localparam int unsigned VAC_R_W = 14;
  localparam int unsigned VAC_WAITK_W = 7;
  localparam int unsigned VAC_CNT_W = 32;
  localparam int unsigned VAC_DIV_W = 5;
  localparam int unsigned VAC_STEP_W = 3;
  localparam int unsigned VAC_EXP_W = 4;
  // ==========================================================
  // Oscillator serial word layout
  localparam int unsigned VAC_BAND_LSB = 7;
  localparam int unsigned VAC_BAND_MSB = 14;
  localparam int unsigned VAC_ADDR_ID_MSB = 6;
  localparam int unsigned VAC_TOP_BIT = 15;
  // ==========================================================
  // Sequence figures
  localparam logic [VAC_STEP_W-1:0] VAC_LAST_STEP = 3'h7;
  localparam logic [VAC_CNT_W-1:0] VAC_WAIT_UNIT = 32'h0000_0014;
  localparam logic [VAC_CNT_W-1:0] VAC_XFER_CLKS = 32'h0000_0014;
  localparam logic [VAC_CNT_W-1:0] VAC_SHIFT_CLKS = 32'h0000_0010;
  localparam logic [VAC_CNT_W-1:0] VAC_MAN_CLKS = 32'h0000_0010;
  localparam logic [VAC_BAND_W-1:0] VAC_BAND_RST = 8'h00;
  localparam logic [VAC_BAND_W-1:0] VAC_BAND_FIRST = 8'h80;
  localparam int unsigned VAC_CLK_PERIOD_NS = 50;
  // ==========================================================
  // Exponent tables, entry i at bits [4i+3:4i]
  localparam logic [31:0] VAC_N_LUT = 32'h8765_3210;
  localparam logic [15:0] VAC_M_LUT = 16'h5420;

  typedef enum logic [2:0] {
    VAC_IDLE,
    VAC_WAIT,
    VAC_MEAS,
    VAC_SEND,
    VAC_MAN
  } vac_state_type;
endpackage : vac_pkg

// ### vac_cal_fsm.sv
`timescale 1ns/1ns
// Function
// - Send band bits, keep address and identifier
// - Relock once on unlock when enabled
// - Frequency change starts calibration unless disabled
// - Same-value rewrite reruns calibration, frequency unchanged
// - Window is R times two to n
// - Expected count is floor of N times 2^n
// - Machine clock is reference divided by 2^m
// - Machine and serial link share divided clock
// - Step: wait, measure, twenty-clock transfer, eight steps
// - Wait count k from seven-bit field
// - Total time follows worst-case duration formula
// - Resolution codes map to n table
// - Load pending fraction after band chosen
// - Calibration bit high only during search
// - Chosen band readable after every run
// - Disabled: serial word sent directly, sixteen clocks
module vac_cal_fsm (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cal_disable,
  input wire logic relock_enable,
  input wire logic lock_detect,
  input wire logic freq_change_req,
  input wire logic [vac_pkg::VAC_INT_W-1:0] int_part,
  input wire logic [vac_pkg::VAC_FRAC_W-1:0] divider_fraction_part,
  input wire logic [vac_pkg::VAC_R_W-1:0] ref_div_ratio,
  input wire logic [2:0] resolution_code,
  input wire logic [vac_pkg::VAC_WAITK_W-1:0] wait_k,
  input wire logic [1:0] clk_div_sel,
  input wire logic [vac_pkg::VAC_WORD_W-1:0] osc_serial_word,
  input wire logic osc_word_write,
  input wire logic osc_cycle_in,
  output logic osc_cal_bit,
  output logic osc_link_clk,
  output logic osc_link_data,
  output logic osc_link_latch,
  output logic [vac_pkg::VAC_BAND_W-1:0] band_readback,
  output logic [vac_pkg::VAC_FRAC_W-1:0] modulator_fraction,
  output logic modulator_load,
  output logic cal_busy
);
  import vac_pkg::*;

  // ==========================================================
  // Configuration decode
  logic [VAC_EXP_W-1:0] res_exp;
  logic [VAC_EXP_W-1:0] div_exp;
  logic [VAC_DIV_W-1:0] div_mask;
  logic [VAC_INT_W+VAC_FRAC_W+8-1:0] n_scaled;
  logic [VAC_CNT_W-1:0] exp_cnt;
  logic [VAC_CNT_W-1:0] win_len;
  logic [VAC_CNT_W-1:0] wait_len;

  assign res_exp = VAC_N_LUT[{resolution_code, 2'b00} +: VAC_EXP_W];
  assign div_exp = VAC_M_LUT[{clk_div_sel, 2'b00} +: VAC_EXP_W];
  assign div_mask = VAC_DIV_W'((VAC_DIV_W+1)'(1) << div_exp) - VAC_DIV_W'(1);
  assign n_scaled = {8'h00, int_part, divider_fraction_part} << res_exp;
  assign exp_cnt = VAC_CNT_W'(n_scaled[VAC_INT_W+VAC_FRAC_W+8-1:VAC_FRAC_W]);
  assign win_len = VAC_CNT_W'({18'h0, ref_div_ratio} << res_exp);
  assign wait_len = VAC_CNT_W'(VAC_WAIT_UNIT * (VAC_CNT_W'(wait_k) + VAC_CNT_W'(1)));

  // ==========================================================
  // Divided machine clock tick
  logic [VAC_DIV_W-1:0] div_q;
  logic tick;

  assign tick = (div_q == div_mask);

  always_ff @(posedge core_clk) begin
    if (srst || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + VAC_DIV_W'(1);
    end
  end

  // ==========================================================
  // Oscillator cycle input synchroniser and edge
  logic [2:0] osc_sync_q;
  logic osc_edge;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      osc_sync_q <= 3'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], osc_cycle_in};
    end
  end

  assign osc_edge = osc_sync_q[1] & ~osc_sync_q[2];

  // ==========================================================
  // Sequencer
  vac_state_type state_q;
  logic [VAC_CNT_W-1:0] tmr_q;
  logic [VAC_STEP_W-1:0] step_q;
  logic relock_used_q;
  logic armed_q;
  logic relock_go;
  logic start;
  logic man_go;
  logic meas_end;
  logic wait_end;
  logic send_end;
  logic run_done;

  assign relock_go = relock_enable & ~lock_detect & armed_q & ~relock_used_q & (state_q == VAC_IDLE);
  assign start = (freq_change_req & ~cal_disable) | relock_go;
  assign man_go = cal_disable & osc_word_write & (state_q == VAC_IDLE) & ~start;
  assign wait_end = (state_q == VAC_WAIT) & tick & (tmr_q == wait_len - VAC_CNT_W'(1));
  assign meas_end = (state_q == VAC_MEAS) & (tmr_q == win_len - VAC_CNT_W'(1));
  assign send_end = (state_q == VAC_SEND) & tick & (tmr_q == VAC_XFER_CLKS - VAC_CNT_W'(1));
  assign run_done = send_end & (step_q == VAC_LAST_STEP);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= VAC_IDLE;
      tmr_q <= '0;
      step_q <= '0;
    end else if (start) begin
      state_q <= VAC_WAIT;
      tmr_q <= '0;
      step_q <= '0;
    end else begin
      case (state_q)
        VAC_IDLE: begin
          if (man_go) begin
            state_q <= VAC_MAN;
            tmr_q <= '0;
          end
        end
        VAC_WAIT: begin
          if (wait_end) begin
            state_q <= VAC_MEAS;
            tmr_q <= '0;
          end else if (tick) begin
            tmr_q <= tmr_q + VAC_CNT_W'(1);
          end
        end
        VAC_MEAS: begin
          if (meas_end) begin
            state_q <= VAC_SEND;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q + VAC_CNT_W'(1);
          end
        end
        VAC_SEND: begin
          if (send_end) begin
            state_q <= run_done ? VAC_IDLE : VAC_WAIT;
            step_q <= step_q + VAC_STEP_W'(1);
            tmr_q <= '0;
          end else if (tick) begin
            tmr_q <= tmr_q + VAC_CNT_W'(1);
          end
        end
        VAC_MAN: begin
          if (tick && tmr_q == VAC_MAN_CLKS - VAC_CNT_W'(1)) begin
            state_q <= VAC_IDLE;
            tmr_q <= '0;
          end else if (tick) begin
            tmr_q <= tmr_q + VAC_CNT_W'(1);
          end
        end
        default: begin
          state_q <= VAC_IDLE;
          tmr_q <= '0;
        end
      endcase
    end
  end

  // Single relock attempt per programmed frequency
  always_ff @(posedge core_clk) begin
    if (srst) begin
      relock_used_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      if (freq_change_req) begin
        relock_used_q <= 1'b0;
      end else if (relock_go) begin
        relock_used_q <= 1'b1;
      end
      if (run_done) begin
        armed_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Count and band search
  logic [VAC_CNT_W-1:0] meas_q;
  logic [VAC_BAND_W-1:0] band_q;
  logic [VAC_BAND_W-1:0] band_next;

  always_ff @(posedge core_clk) begin
    if (srst || wait_end) begin
      meas_q <= '0;
    end else if (state_q == VAC_MEAS && osc_edge) begin
      meas_q <= meas_q + VAC_CNT_W'(1);
    end
  end

  always_comb begin
    band_next = band_q;
    if (meas_q > exp_cnt) begin
      band_next[~step_q] = 1'b0;
    end
    if (step_q != VAC_LAST_STEP) begin
      band_next[~step_q - VAC_STEP_W'(1)] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      band_q <= VAC_BAND_RST;
    end else if (start) begin
      band_q <= VAC_BAND_FIRST;
    end else if (meas_end) begin
      band_q <= band_next;
    end
  end

  // ==========================================================
  // Oscillator serial link
  logic [VAC_WORD_W-1:0] shift_q;
  logic shifting;

  assign shifting = tick & (tmr_q < VAC_SHIFT_CLKS) & ((state_q == VAC_SEND) || (state_q == VAC_MAN));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_q <= '0;
    end else if (meas_end) begin
      shift_q <= {osc_serial_word[VAC_TOP_BIT], band_next, osc_serial_word[VAC_ADDR_ID_MSB:0]};
    end else if (man_go) begin
      shift_q <= osc_serial_word;
    end else if (shifting) begin
      shift_q <= {shift_q[VAC_WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      osc_link_data <= 1'b0;
      osc_link_clk <= 1'b0;
      osc_link_latch <= 1'b0;
    end else begin
      if (shifting) begin
        osc_link_data <= shift_q[VAC_WORD_W-1];
      end
      osc_link_clk <= shifting;
      osc_link_latch <= tick & (((state_q == VAC_SEND) && tmr_q == VAC_SHIFT_CLKS)
        || ((state_q == VAC_MAN) && tmr_q == VAC_MAN_CLKS - VAC_CNT_W'(1)));
    end
  end

  // ==========================================================
  // Results and modulator hand-off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      osc_cal_bit <= 1'b0;
      band_readback <= VAC_BAND_RST;
      modulator_fraction <= '0;
      modulator_load <= 1'b0;
    end else begin
      if (start) begin
        osc_cal_bit <= 1'b1;
      end else if (run_done) begin
        osc_cal_bit <= 1'b0;
      end
      if (run_done) begin
        band_readback <= band_q;
      end
      if (run_done || (freq_change_req && cal_disable)) begin
        modulator_fraction <= divider_fraction_part;
      end
      modulator_load <= run_done || (freq_change_req && cal_disable);
    end
  end

  assign cal_busy = (state_q != VAC_IDLE);

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_cal_bit_search: assert property (osc_cal_bit == (state_q inside {VAC_WAIT, VAC_MEAS, VAC_SEND}))
    else $error("calibration bit does not track search");
  a_freq_starts: assert property (freq_change_req && !cal_disable |=> state_q == VAC_WAIT && osc_cal_bit)
    else $error("frequency change did not start calibration");
  a_relock_once: assert property (relock_go && !freq_change_req |=> relock_used_q && state_q == VAC_WAIT)
    else $error("relock attempt not recorded");
  a_addr_kept: assert property (meas_end && !start |=> shift_q[6:0] == $past(osc_serial_word[6:0]))
    else $error("address or identifier altered");
  a_window_len: assert property ($rose(state_q == VAC_MEAS) |-> win_len == VAC_CNT_W'(ref_div_ratio) * (32'h1 << res_exp))
    else $error("window length wrong");
  a_wait_then_meas: assert property (wait_end && !start |=> state_q == VAC_MEAS && meas_q == '0)
    else $error("wait did not end in measurement");
  a_done_result: assert property (run_done && !start |=> modulator_load && band_readback == $past(band_q) && !osc_cal_bit)
    else $error("result not published at end of run");
  a_manual_direct: assert property (man_go |=> state_q == VAC_MAN && shift_q == $past(osc_serial_word))
    else $error("manual word not taken directly");
  a_sar_first: assert property (start |=> band_q == VAC_BAND_FIRST && step_q == '0)
    else $error("search did not start at top trial bit");
  a_exp_lut: assert property (res_exp == ((resolution_code < 3'h4) ? {1'b0, resolution_code} : {1'b0, resolution_code} + 4'h1))
    else $error("resolution code mapping wrong");

  c_full_run: cover property (run_done);
  c_relock: cover property (relock_go);
  c_manual: cover property (man_go ##[1:1000] osc_link_latch);
  c_restart: cover property (state_q == VAC_MEAS && freq_change_req && !cal_disable);
endmodule : vac_cal_fsm

// ### vac_osc_model.sv
`timescale 1ns/1ns
// ==========================================================
// Oscillator side: serial word sink and band-rate edge source
module vac_osc_model (
  input wire logic core_clk,
  input wire logic osc_cal_bit,
  input wire logic osc_link_clk,
  input wire logic osc_link_data,
  input wire logic osc_link_latch,
  output logic osc_cycle_in,
  output logic [15:0] word_q
);
  logic [15:0] sh_q = 16'h0000;
  logic [10:0] acc_q = 11'h000;
  logic [7:0] band_q = 8'h00;
  logic cal_q = 1'b0;
  logic [11:0] acc_d;
  logic [15:0] word_d;
  initial osc_cycle_in = 1'b0;
  initial word_q = 16'h0000;
  // Edge rate (4b+1)/4096 per cycle: 2b or 2b+1 edges in 2048 cycles
  assign acc_d = {1'b0, acc_q} + {2'h0, band_q, 2'h1};
  assign word_d = osc_link_clk ? {sh_q[14:0], osc_link_data} : sh_q;
  always @(posedge core_clk) begin
    acc_q <= acc_d[10:0];
    if (acc_d[11]) osc_cycle_in <= !osc_cycle_in;
    cal_q <= osc_cal_bit;
    if (osc_link_clk) sh_q <= word_d;
    if (osc_link_latch) begin
      word_q <= word_d;
      band_q <= word_d[14:7];
    end
    // Search starts on the mid trial
    if (osc_cal_bit && !cal_q) band_q <= 8'h80;
  end
endmodule : vac_osc_model

// ### tb.sv
`timescale 1ns/1ns
module tb;
  import vac_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cal_disable = 1'b0;
  logic relock_enable = 1'b0;
  logic lock_detect = 1'b1;
  logic freq_change_req = 1'b0;
  logic osc_word_write = 1'b0;
  logic [VAC_INT_W-1:0] int_part = 19'h00000;
  logic [VAC_FRAC_W-1:0] divider_fraction_part = 24'h000000;
  logic [VAC_WAITK_W-1:0] wait_k = 7'h00;
  logic [1:0] clk_div_sel = 2'h0;
  logic [2:0] res_code = 3'h7;
  logic [VAC_R_W-1:0] ref_ratio = 14'h0008;
  logic [VAC_WORD_W-1:0] osc_serial_word = 16'h0000;
  logic osc_cycle_in, osc_cal_bit, osc_link_clk, osc_link_data, osc_link_latch, modulator_load, cal_busy;
  logic [VAC_BAND_W-1:0] band_readback;
  logic [VAC_FRAC_W-1:0] modulator_fraction;
  logic [15:0] word;
  logic [47:0] exp_q[$];
  logic [47:0] last_e;
  logic [47:0] got_e;
  int errors = 0;
  int compares = 0;
  int seed = 32'hAFF5C727;
  int mexp[4] = '{0, 2, 4, 5};

  always #25 core_clk = ~core_clk;

  vac_cal_fsm u_vac_cal_fsm (.core_clk(core_clk), .srst(srst), .cal_disable(cal_disable),
    .relock_enable(relock_enable), .lock_detect(lock_detect), .freq_change_req(freq_change_req),
    .int_part(int_part), .divider_fraction_part(divider_fraction_part), .ref_div_ratio(ref_ratio),
    .resolution_code(res_code), .wait_k(wait_k), .clk_div_sel(clk_div_sel), .osc_serial_word(osc_serial_word),
    .osc_word_write(osc_word_write), .osc_cycle_in(osc_cycle_in), .osc_cal_bit(osc_cal_bit),
    .osc_link_clk(osc_link_clk), .osc_link_data(osc_link_data), .osc_link_latch(osc_link_latch),
    .band_readback(band_readback), .modulator_fraction(modulator_fraction),
    .modulator_load(modulator_load), .cal_busy(cal_busy));

  vac_osc_model u_vac_osc_model (.core_clk(core_clk), .osc_cal_bit(osc_cal_bit),
    .osc_link_clk(osc_link_clk), .osc_link_data(osc_link_data), .osc_link_latch(osc_link_latch),
    .osc_cycle_in(osc_cycle_in), .word_q(word));

  // ==========================================================
  // Checking and closing
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic wait_idle();
    int i;
    for (i = 0; i < 40000 && cal_busy !== 1'b0; i++) @(posedge core_clk);
    if (i == 40000) begin
      errors++;
      give_verdict();
    end
  endtask : wait_idle

  // ==========================================================
  // One run; expected count 2t+1 puts the boundary right above band t
  task automatic run_cal(input logic [7:0] t, input int abort);
    logic [15:0] w;
    w = 16'($random(seed));
    last_e = {t[6:0], 1'b1, 16'h0000, t, w[15], t, w[6:0]};
    exp_q.push_back(last_e);
    @(posedge core_clk);
    osc_serial_word <= w;
    int_part <= {18'h00000, t[7]};
    divider_fraction_part <= last_e[47:24];
    wait_k <= 7'($random(seed) & 3);
    clk_div_sel <= 2'($random(seed) & 1);
    freq_change_req <= 1'b1;
    @(posedge core_clk);
    freq_change_req <= 1'b0;
    @(posedge core_clk);
    check("cal bit", osc_cal_bit, 48'h1);
    if (abort > 0) begin
      repeat (abort) @(posedge core_clk);
      freq_change_req <= 1'b1;
      @(posedge core_clk);
      freq_change_req <= 1'b0;
    end
    wait_idle();
    check("cal bit", osc_cal_bit, 48'h0);
  endtask : run_cal

  always @(posedge core_clk) begin
    if (modulator_load === 1'b1) begin
      got_e = exp_q.size() > 0 ? exp_q.pop_front() : 48'h0;
      check("fraction", modulator_fraction, got_e[47:24]);
      check("band", band_readback, got_e[23:16]);
      check("osc word", word, got_e[15:0]);
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    int i;
    int n;
    int last;
    int m;
    logic [15:0] w;
    repeat (4) @(posedge core_clk);
    check("reset", {cal_busy, osc_cal_bit, modulator_load, band_readback}, 48'h0);
    srst <= 1'b0;
    run_cal(8'($random(seed)), 0);
    run_cal(8'hFF, 500);
    relock_enable <= 1'b1;
    lock_detect <= 1'b0;
    exp_q.push_back(last_e);
    repeat (3) @(posedge core_clk);
    check("relock", cal_busy, 48'h1);
    wait_idle();
    repeat (40) @(posedge core_clk);
    check("one relock", cal_busy, 48'h0);
    lock_detect <= 1'b1;
    cal_disable <= 1'b1;
    for (m = 0; m < 4; m++) begin
      w = 16'($random(seed));
      @(posedge core_clk);
      clk_div_sel <= 2'(m);
      res_code <= 3'($random(seed));
      ref_ratio <= 14'($random(seed));
      osc_serial_word <= w;
      osc_word_write <= 1'b1;
      @(posedge core_clk);
      osc_word_write <= 1'b0;
      last = 0;
      n = 0;
      for (i = 0; i < 3000 && osc_link_latch !== 1'b1; i++) begin
        @(posedge core_clk);
        if (osc_link_clk === 1'b1) begin
          if (n > 0) check("link gap", 48'(i - last), 48'(1 << mexp[m]));
          last = i;
          n++;
        end
      end
      if (i == 3000) begin
        errors++;
        give_verdict();
      end
      check("link bits", 48'(n), 48'd16);
      @(posedge core_clk);
      check("manual word", word, {32'h0, w});
    end
    last_e = {24'($random(seed)), last_e[23:16], w};
    exp_q.push_back(last_e);
    @(posedge core_clk);
    divider_fraction_part <= last_e[47:24];
    freq_change_req <= 1'b1;
    @(posedge core_clk);
    freq_change_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("no run", cal_busy, 48'h0);
    check("loads seen", 48'(exp_q.size()), 48'h0);
    give_verdict();
  end
endmodule : tb
